/* verilog/shrs_sequencer.sv */
// Hot reset sequencer with an AXI4-Lite register slave.
// Assumes all link status inputs are synchronous to CORE_CLK and
// that the EEPROM loader and training logic sit outside.
`timescale 1ns/1ps
`default_nettype none
`include "shrs_consts.svh"

module shrs_sequencer #(
    parameter int PORTS     = 4,
    parameter int TRAIN_CYC = `SHRS_TRAIN_MS * `SHRS_CLK_KHZ,
    parameter int CRS_CYC   = `SHRS_CRS_MS * `SHRS_CLK_KHZ,
    parameter int PROP_CYC  = `SHRS_PROP_CYC,
    parameter int LRST_CYC  = `SHRS_LRST_CYC
) (
    input  wire logic             CORE_CLK,
    input  wire logic             RESET_N,
    input  wire logic             S_AXI_AWVALID,
    output var  logic             S_AXI_AWREADY,
    input  wire logic [3:0]       S_AXI_AWADDR,
    input  wire logic             S_AXI_WVALID,
    output var  logic             S_AXI_WREADY,
    input  wire logic [31:0]      S_AXI_WDATA,
    input  wire logic [3:0]       S_AXI_WSTRB,
    output var  logic             S_AXI_BVALID,
    input  wire logic             S_AXI_BREADY,
    output var  logic [1:0]       S_AXI_BRESP,
    input  wire logic             S_AXI_ARVALID,
    output var  logic             S_AXI_ARREADY,
    input  wire logic [3:0]       S_AXI_ARADDR,
    output var  logic             S_AXI_RVALID,
    input  wire logic             S_AXI_RREADY,
    output var  logic [31:0]      S_AXI_RDATA,
    output var  logic [1:0]       S_AXI_RRESP,
    input  wire logic             UP_TS1_HOT_RESET,
    input  wire logic             UP_DL_DOWN,
    input  wire logic [PORTS-1:0] DS_LINK_UP,
    input  wire logic             EE_MODE_NEEDED,
    input  wire logic             HALT_PIN,
    input  wire logic             EE_LOAD_DONE,
    input  wire logic             EE_LOAD_ERROR,
    input  wire logic [3:0]       EE_ERR_CODE,
    input  wire logic             EE_SET_HALT,
    output var  logic [PORTS-1:0] DS_HOT_RESET_TS1,
    output var  logic             CORE_RESET_N,
    output var  logic             REG_RESET,
    output var  logic             TRAIN_START,
    output var  logic             QUASI_RESET,
    output var  logic             EE_LOAD_START,
    output var  logic             SEC_BUS_RESET
);

    ////////////////////////////////////////////////////////////////
    // Declarations
    shrs_pkg::shrs_state_type state_reg;   // Sequence step
    shrs_pkg::shrs_ctl_type   ctl_reg;     // Control fields
    logic        sts_halt_reg;             // Halt pin seen
    logic        smb_done_reg;             // Load finished
    logic [3:0]  smb_err_reg;              // Load error code
    logic        sbr_reg;                  // Bridge reset bit
    logic        dl_down_reg;              // Link down history
    logic        sw_pend_reg;              // Trigger written
    logic [15:0] cnt_reg;                  // Step timer
    logic [3:0]  aw_addr_reg;              // Held write address
    logic [31:0] w_data_reg;               // Held write data
    logic [3:0]  w_strb_reg;               // Held strobes
    logic        do_wr;                    // Write performs now
    logic        hot_busy;                 // Reset registers blocked
    logic        trig_ts1;                 // TS1 trigger
    logic        trig_dl;                  // Link down trigger
    logic        trig_sw;                  // Software trigger
    logic        hot_trig;                 // Any trigger
    logic        halt_set;                 // Halt set event
    logic        halt_clr;                 // Halt clear write

    ////////////////////////////////////////////////////////////////
    // Helpers

    // Known register offset
    function automatic logic mapped(input logic [3:0] a);
        mapped = (a == `SHRS_OFS_CTRL) || (a == `SHRS_OFS_STAT) ||
                 (a == `SHRS_OFS_SMBSTS) || (a == `SHRS_OFS_BRIDGE);
    endfunction : mapped

    // Register cleared by a hot reset
    function automatic logic hot_reg(input logic [3:0] a);
        hot_reg = (a == `SHRS_OFS_STAT) || (a == `SHRS_OFS_BRIDGE);
    endfunction : hot_reg

    // Bits that hardware clears are blocked in every step but idle and halt
    assign hot_busy = (state_reg != shrs_pkg::ST_IDLE) &&
                      (state_reg != shrs_pkg::ST_HALT);

    ////////////////////////////////////////////////////////////////
    // Triggers

    // Link down counts only on its rising edge
    assign trig_dl  = UP_DL_DOWN && !dl_down_reg &&
                      !ctl_reg.ld_dis;                     // RULE2
    assign trig_ts1 = UP_TS1_HOT_RESET;                    // RULE3
    // Fires once the write response has been taken
    assign trig_sw  = sw_pend_reg && !S_AXI_BVALID;        // RULE19
    assign hot_trig = trig_ts1 || trig_dl || trig_sw;      // RULE1

    // Link down history
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            dl_down_reg <= 1'b0;
        end else begin
            dl_down_reg <= UP_DL_DOWN;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Sequence
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_reg <= shrs_pkg::ST_IDLE;
            cnt_reg   <= 16'h0000;
        end else begin
            case (state_reg)
                shrs_pkg::ST_IDLE: begin
                    cnt_reg <= 16'h0000;
                    if (hot_trig) begin
                        state_reg <= shrs_pkg::ST_PROP;    // RULE21
                    end
                end
                shrs_pkg::ST_PROP: begin
                    // TS1 held long enough for the links to see it
                    if (cnt_reg == 16'(PROP_CYC - 1)) begin
                        cnt_reg   <= 16'h0000;
                        state_reg <= shrs_pkg::ST_LRST;
                    end else begin
                        cnt_reg <= cnt_reg + 16'h0001;
                    end
                end
                shrs_pkg::ST_LRST: begin
                    if (cnt_reg == 16'(LRST_CYC - 1)) begin
                        cnt_reg   <= 16'h0000;
                        state_reg <= shrs_pkg::ST_TRAIN;
                    end else begin
                        cnt_reg <= cnt_reg + 16'h0001;
                    end
                end
                // Training only starts; quasi-reset follows at once
                shrs_pkg::ST_TRAIN: begin
                    state_reg <= shrs_pkg::ST_QUASI;       // RULE7
                end
                shrs_pkg::ST_QUASI: begin
                    if (EE_MODE_NEEDED && !ctl_reg.ee_dis) begin
                        state_reg <= shrs_pkg::ST_EELOAD;  // RULE10
                    end else if (ctl_reg.halt) begin
                        state_reg <= shrs_pkg::ST_HALT;
                    end else begin
                        state_reg <= shrs_pkg::ST_IDLE;
                    end
                end
                shrs_pkg::ST_EELOAD: begin
                    // Error aborts the load at once
                    if (EE_LOAD_ERROR) begin
                        state_reg <= shrs_pkg::ST_HALT;    // RULE12
                    end else if (EE_LOAD_DONE) begin
                        state_reg <= (ctl_reg.halt || EE_SET_HALT) ?
                                     shrs_pkg::ST_HALT :
                                     shrs_pkg::ST_IDLE;
                    end
                end
                shrs_pkg::ST_HALT: begin                   // RULE14
                    if (!ctl_reg.halt) begin
                        state_reg <= shrs_pkg::ST_IDLE;    // RULE16
                    end
                end
                default: begin
                    state_reg <= shrs_pkg::ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // Step outputs, all registered from the current step
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            DS_HOT_RESET_TS1 <= '0;
            CORE_RESET_N     <= 1'b1;
            REG_RESET        <= 1'b0;
            TRAIN_START      <= 1'b0;
            QUASI_RESET      <= 1'b0;
            EE_LOAD_START    <= 1'b0;
        end else begin
            // Only links that are up carry the hot reset on
            DS_HOT_RESET_TS1 <= (state_reg == shrs_pkg::ST_PROP) ?
                                DS_LINK_UP : '0;           // RULE4
            // PLL, SerDes and SMBus sit outside this reset
            CORE_RESET_N <= !((state_reg == shrs_pkg::ST_LRST) ||
                              (state_reg == shrs_pkg::ST_HALT)); // RULE5
            REG_RESET    <= (state_reg == shrs_pkg::ST_PROP) &&
                            (cnt_reg == 16'(PROP_CYC - 1)); // RULE6
            TRAIN_START  <= (state_reg == shrs_pkg::ST_TRAIN); // RULE8
            // Stacks answer retry from training onward
            QUASI_RESET  <= (state_reg == shrs_pkg::ST_TRAIN) ||
                            (state_reg == shrs_pkg::ST_QUASI) ||
                            (state_reg == shrs_pkg::ST_EELOAD) ||
                            (state_reg == shrs_pkg::ST_HALT); // RULE9
            EE_LOAD_START <= (state_reg == shrs_pkg::ST_QUASI) &&
                             EE_MODE_NEEDED && !ctl_reg.ee_dis;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Bus write path; runs in every step, never reset by the sequence
    assign do_wr = !S_AXI_AWREADY && !S_AXI_WREADY &&
                   !S_AXI_BVALID;                          // RULE17

    // Address and data taken in either order
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY  <= 1'b1;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= `SHRS_RESP_OK;
            aw_addr_reg   <= 4'h0;
            w_data_reg    <= 32'h0000_0000;
            w_strb_reg    <= 4'h0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                S_AXI_AWREADY <= 1'b0;
                aw_addr_reg   <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                S_AXI_WREADY <= 1'b0;
                w_data_reg   <= S_AXI_WDATA;
                w_strb_reg   <= S_AXI_WSTRB;
            end
            if (do_wr) begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= mapped(aw_addr_reg) ?
                                `SHRS_RESP_OK : `SHRS_RESP_ERR;
            end
            // Next write only after the answer is taken
            if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID  <= 1'b0;
                S_AXI_AWREADY <= 1'b1;
                S_AXI_WREADY  <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Control register: disables and halt survive the hot reset
    assign halt_set = (state_reg == shrs_pkg::ST_EELOAD) &&
                      (EE_LOAD_ERROR || EE_SET_HALT);      // RULE15
    assign halt_clr = do_wr && w_strb_reg[0] &&
                      (aw_addr_reg == `SHRS_OFS_CTRL) &&
                      !w_data_reg[`SHRS_CTL_HALT];

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctl_reg     <= shrs_pkg::shrs_ctl_type'(3'h0);
            sw_pend_reg <= 1'b0;
        end else begin
            if (do_wr && w_strb_reg[0] &&
                (aw_addr_reg == `SHRS_OFS_CTRL)) begin
                ctl_reg.ld_dis <= w_data_reg[`SHRS_CTL_LDDIS];
                ctl_reg.ee_dis <= w_data_reg[`SHRS_CTL_EEDIS];
                // Trigger accepted only while idle
                if (w_data_reg[`SHRS_CTL_TRIG] &&
                    state_reg == shrs_pkg::ST_IDLE) begin
                    sw_pend_reg <= 1'b1;                   // RULE19
                end
            end
            if (state_reg != shrs_pkg::ST_IDLE) begin
                sw_pend_reg <= 1'b0;
            end
            // Set wins over a clear in the same cycle
            if (halt_set) begin
                ctl_reg.halt <= 1'b1;                      // RULE12
            end else if (halt_clr) begin
                ctl_reg.halt <= 1'b0;                      // RULE16
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Status, SMBus status and bridge control
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sts_halt_reg <= 1'b0;
            smb_done_reg <= 1'b0;
            smb_err_reg  <= 4'h0;
            sbr_reg      <= 1'b0;
        end else begin
            // Non-sticky fields return to reset value
            if (REG_RESET) begin
                sts_halt_reg <= 1'b0;                      // RULE6
                sbr_reg      <= 1'b0;
            end else if (do_wr && w_strb_reg[0] && !hot_busy &&
                         aw_addr_reg == `SHRS_OFS_BRIDGE) begin
                sbr_reg <= w_data_reg[`SHRS_BR_SBR];       // RULE20
            end
            if (state_reg == shrs_pkg::ST_EELOAD && HALT_PIN) begin
                sts_halt_reg <= 1'b1;                      // RULE11
            end
            // Load status kept by the SMBus side
            // Finish wins over the start clear in the same cycle
            if (state_reg == shrs_pkg::ST_EELOAD &&
                (EE_LOAD_ERROR || EE_LOAD_DONE)) begin
                smb_done_reg <= 1'b1;                      // RULE13
            end else if (EE_LOAD_START) begin
                smb_done_reg <= 1'b0;
            end
            if (state_reg == shrs_pkg::ST_EELOAD && EE_LOAD_ERROR) begin
                smb_err_reg <= EE_ERR_CODE;                // RULE12
            end
        end
    end

    // Bridge reset pin follows its bit
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            SEC_BUS_RESET <= 1'b0;
        end else begin
            SEC_BUS_RESET <= sbr_reg;                      // RULE20
        end
    end

    ////////////////////////////////////////////////////////////////
    // Bus read path; one cycle from address to data
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0000_0000;
            S_AXI_RRESP   <= `SHRS_RESP_OK;
        end else begin
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_ARREADY <= 1'b0;
                S_AXI_RVALID  <= 1'b1;
                S_AXI_RRESP   <= mapped(S_AXI_ARADDR) ?
                                 `SHRS_RESP_OK : `SHRS_RESP_ERR;
                S_AXI_RDATA   <= 32'h0000_0000;
                // Reset registers read zero mid sequence
                if (!(hot_busy && hot_reg(S_AXI_ARADDR))) begin // RULE18
                    case (S_AXI_ARADDR)
                        `SHRS_OFS_CTRL:
                            S_AXI_RDATA <= {28'h0, ctl_reg, 1'b0};
                        `SHRS_OFS_STAT:
                            S_AXI_RDATA <= {31'h0, sts_halt_reg};
                        `SHRS_OFS_SMBSTS:
                            S_AXI_RDATA <= {24'h0, smb_err_reg,
                                            3'h0, smb_done_reg};
                        `SHRS_OFS_BRIDGE:
                            S_AXI_RDATA <= {31'h0, sbr_reg};
                        default:
                            S_AXI_RDATA <= 32'h0000_0000;
                    endcase
                end
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID  <= 1'b0;
                S_AXI_ARREADY <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);

    // Time since the hot reset condition cleared
    logic [31:0] clr_cnt_reg;
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            clr_cnt_reg <= 32'h0;
        end else if (state_reg == shrs_pkg::ST_LRST) begin
            clr_cnt_reg <= 32'h0;
        end else if (clr_cnt_reg != 32'hffff_ffff) begin
            clr_cnt_reg <= clr_cnt_reg + 32'h1;
        end
    end

    sequence s_prop;
        state_reg == shrs_pkg::ST_PROP;
    endsequence
    sequence s_lrst;
        state_reg == shrs_pkg::ST_LRST;
    endsequence

    property p_trig;
        state_reg == shrs_pkg::ST_IDLE && hot_trig |=> s_prop;
    endproperty
    a_trig: assert property (p_trig) else $error("No start"); // RULE1

    property p_lddis;
        state_reg == shrs_pkg::ST_IDLE && ctl_reg.ld_dis &&
        !trig_ts1 && !trig_sw |=> state_reg == shrs_pkg::ST_IDLE;
    endproperty
    a_lddis: assert property (p_lddis) else $error("Link down leak"); // RULE2

    property p_ts1;
        state_reg == shrs_pkg::ST_IDLE && UP_TS1_HOT_RESET |=> s_prop;
    endproperty
    a_ts1: assert property (p_ts1) else $error("TS1 lost"); // RULE3

    property p_order;
        s_prop ##1 s_lrst |-> s_lrst [*4] ##1
        state_reg == shrs_pkg::ST_TRAIN ##1
        state_reg == shrs_pkg::ST_QUASI;
    endproperty
    a_order: assert property (p_order) else $error("Bad order"); // RULE21

    property p_prop;
        s_prop |=> DS_HOT_RESET_TS1 == $past(DS_LINK_UP);
    endproperty
    a_prop: assert property (p_prop) else $error("TS1 not sent"); // RULE4

    property p_core;
        s_lrst |=> !CORE_RESET_N;
    endproperty
    a_core: assert property (p_core) else $error("Logic not reset"); // RULE5

    property p_train;
        TRAIN_START |-> clr_cnt_reg <= 32'(TRAIN_CYC);
    endproperty
    a_train: assert property (p_train) else $error("Late training"); // RULE8

    property p_crs;
        state_reg == shrs_pkg::ST_TRAIN |=> QUASI_RESET &&
        clr_cnt_reg <= 32'(CRS_CYC);
    endproperty
    a_crs: assert property (p_crs) else $error("No retry state"); // RULE9

    property p_halt;
        state_reg == shrs_pkg::ST_HALT |=> !CORE_RESET_N;
    endproperty
    a_halt: assert property (p_halt) else $error("Halt not held"); // RULE14

    property p_hset;
        !$past(ctl_reg.halt) && ctl_reg.halt |-> $past(halt_set);
    endproperty
    a_hset: assert property (p_hset) else $error("Halt set wrongly"); // RULE15

    property p_err;
        state_reg == shrs_pkg::ST_EELOAD && EE_LOAD_ERROR |=>
        ctl_reg.halt && smb_done_reg && smb_err_reg == $past(EE_ERR_CODE);
    endproperty
    a_err: assert property (p_err) else $error("Error not logged"); // RULE12

    property p_rd0;
        S_AXI_ARVALID && S_AXI_ARREADY && hot_busy &&
        hot_reg(S_AXI_ARADDR) |=> S_AXI_RDATA == 32'h0;
    endproperty
    a_rd0: assert property (p_rd0) else $error("Read not zero"); // RULE18

    property p_swt;
        sw_pend_reg && S_AXI_BVALID |-> state_reg == shrs_pkg::ST_IDLE;
    endproperty
    a_swt: assert property (p_swt) else $error("Start before answer"); // RULE19

endmodule : shrs_sequencer
`default_nettype wire

/* shared/shrs_consts.svh */
// Constants of the hot reset sequencer: offsets, bit positions,
// reset values and timing figures. Assumes a 10 MHz core clock.
// Contract
// RULE1: Start on TS1, link down, or software
// RULE2: Disable bit blocks link down trigger
// RULE3: Disable bit spares TS1 and software triggers
// RULE4: First send hot reset TS1 downstream
// RULE5: Reset all logic except PLL, SerDes, SMBus
// RULE6: Reset non-sticky register fields only
// RULE7: Start training, then enter quasi-reset
// RULE8: Links train within 20 ms
// RULE9: Stacks answer retry within 100 ms
// RULE10: Load EEPROM when mode needs, not disabled
// RULE11: Halt pin sets status halt bit
// RULE12: Load error aborts, sets halt, logs
// RULE13: Done flag set on finish or error
// RULE14: Halt holds logic in reset
// RULE15: Halt set only by error or EEPROM
// RULE16: Stay halted until agent clears bit
// RULE17: Slave access path never interrupted
// RULE18: Reset registers read zero, drop writes
// RULE19: Complete trigger write before starting
// RULE20: Bridge bit starts secondary bus reset
// RULE21: Steps run strictly in order
`ifndef SHRS_CONSTS_SVH
`define SHRS_CONSTS_SVH
`define SHRS_OFS_CTRL    4'h0
`define SHRS_OFS_STAT    4'h4
`define SHRS_OFS_SMBSTS  4'h8
`define SHRS_OFS_BRIDGE  4'hc
`define SHRS_CTL_TRIG    0
`define SHRS_CTL_LDDIS   1
`define SHRS_CTL_EEDIS   2
`define SHRS_CTL_HALT    3
`define SHRS_STS_HALT    0
`define SHRS_SMB_DONE    0
`define SHRS_SMB_ERR_LO  4
`define SHRS_BR_SBR      0
`define SHRS_CTL_RST     4'h0
`define SHRS_RESP_OK     2'h0
`define SHRS_RESP_ERR    2'h2
`define SHRS_CLK_KHZ     10000
`define SHRS_TRAIN_MS    20
`define SHRS_CRS_MS      100
`define SHRS_PROP_CYC    16
`define SHRS_LRST_CYC    4
`endif

/* shared/shrs_pkg.sv */
// Types of the hot reset sequencer.
// Used by the single design module; constants live in the header.
package shrs_pkg;
    // Sequence steps
    typedef enum logic [2:0] {
        ST_IDLE, ST_PROP, ST_LRST, ST_TRAIN,
        ST_QUASI, ST_EELOAD, ST_HALT
    } shrs_state_type;
    // Switch control fields
    typedef struct packed {
        logic halt;
        logic ee_dis;
        logic ld_dis;
    } shrs_ctl_type;
endpackage : shrs_pkg

/* sim/shrs_partner.sv */
// Upstream link partner: raises hot reset TS1 and link down.
// Assumes bench commands synchronous to the core clock.
`timescale 1ns/1ps
`default_nettype none
module shrs_partner (
    input  wire logic clk,
    input  wire logic ts1_go,
    input  wire logic dl_go,
    output var  logic ts1,
    output var  logic dl_down
);
    // Quiet at start, then one cycle behind the command
    initial begin
        ts1 = 1'h0;
        dl_down = 1'h0;
    end
    always @(posedge clk) begin
        ts1     <= ts1_go;
        dl_down <= dl_go;
    end
endmodule : shrs_partner
`default_nettype wire

/* sim/shrs_sequencer_tb.sv */
// Bench for the hot reset sequencer: AXI4-Lite calls and checks.
// Assumes the partner model drives the upstream triggers.
`timescale 1ns/1ps
`default_nettype none
module shrs_sequencer_tb;
    logic clk = 1'h0, rst_n = 1'h0, awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
    logic ts1_go = 1'h0, dl_go = 1'h0, hpin = 1'h0, eee = 1'h0, eem = 1'h1, eed = 1'h0;
    logic [3:0] awa = 4'h0, ara = 4'h0, ecode = 4'h0, ts1_or = 4'h0;
    logic [31:0] wd = 32'h0;
    wire logic awr, wr, bv, arr, rv, core_n, regr, trn, qr, ees, sbr, ts1, dl;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [3:0] dts1;
    int err_count = 0, n_compared = 0, cyc = 0, n_reg = 0, n_trn = 0, n_ee = 0, t;
    // Short training and retry limits only tighten the timing checks
    shrs_sequencer #(.TRAIN_CYC(100), .CRS_CYC(100)) dut (
        .CORE_CLK(clk), .RESET_N(rst_n), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa),
        .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_BVALID(bv),
        .S_AXI_BREADY(br), .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara),
        .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .UP_TS1_HOT_RESET(ts1), .UP_DL_DOWN(dl), .DS_LINK_UP(4'ha), .EE_MODE_NEEDED(eem), .HALT_PIN(hpin),
        .EE_LOAD_DONE(eed), .EE_LOAD_ERROR(eee), .EE_ERR_CODE(ecode), .EE_SET_HALT(1'h0),
        .DS_HOT_RESET_TS1(dts1), .CORE_RESET_N(core_n), .REG_RESET(regr), .TRAIN_START(trn),
        .QUASI_RESET(qr), .EE_LOAD_START(ees), .SEC_BUS_RESET(sbr));
    shrs_partner ptn (.clk(clk), .ts1_go(ts1_go), .dl_go(dl_go), .ts1(ts1), .dl_down(dl));
    always #50 clk = ~clk;
    ////////////////////////////////////////////////////////////
    // Pulse counters, step order and hang limit
    always @(posedge clk) begin
        cyc++;
        ts1_or = ts1_or | dts1;
        if (regr === 1'h1) n_reg++;
        if (trn === 1'h1) chk(n_reg, n_trn + 1);
        if (trn === 1'h1) n_trn++;
        if (ees === 1'h1) n_ee++;
        if (cyc == 5000) begin
            err_count++;
            complete_run();
        end
    end
    task chk(input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("mismatch at %0t exp %h got %h", $time, e, g);
        end
    endtask : chk
    // Write: sample at falling edge, release after the taking edge
    task axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, tb;
        logic [1:0] rs;
        awv <= 1'h1; wv <= 1'h1; awa <= a; wd <= d; br <= 1'h1; tb = 1'h0; t = 0;
        while (tb !== 1'h1 && t < 100) begin
            @(negedge clk); ta = awr & awv; tw = wr & wv; tb = bv; rs = bresp; t++;
            @(posedge clk); if (ta) awv <= 1'h0; if (tw) wv <= 1'h0;
        end
        if (tb !== 1'h1) err_count++;
        chk({30'h0, er}, {30'h0, rs});
    endtask : axi_wr
    task axi_rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ta, tv;
        logic [31:0] d;
        logic [1:0] rs;
        arv <= 1'h1; ara <= a; rr <= 1'h1; tv = 1'h0; t = 0;
        while (tv !== 1'h1 && t < 100) begin
            @(negedge clk); ta = arr & arv; tv = rv; d = rdata; rs = rresp; t++;
            @(posedge clk); if (ta) arv <= 1'h0;
        end
        if (tv !== 1'h1) err_count++;
        chk(e, d);
        chk({30'h0, er}, {30'h0, rs});
    endtask : axi_rd
    // Wait for the sequence to close, then back on a rising edge
    task wait_seq(input int snap);
        t = 0;
        while (!(n_trn > snap && qr === 1'h0 && core_n === 1'h1) && t < 300) begin
            @(negedge clk); t++;
        end
        if (t == 300) err_count++;
        @(posedge clk);
        chk(snap + 1, n_trn);
    endtask : wait_seq
    task complete_run;
        if (err_count == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        axi_rd(4'h0, 32'h0, 2'h0);
        axi_rd(4'h2, 32'h0, 2'h2);
        axi_wr(4'hc, 32'h1, 2'h0);
        @(posedge clk);
        chk(32'h1, sbr);
        axi_wr(4'h0, 32'h7, 2'h0);
        chk(32'h0, dts1);
        wait_seq(0);
        chk(32'ha, ts1_or);
        axi_rd(4'hc, 32'h0, 2'h0);
        axi_rd(4'h0, 32'h6, 2'h0);
        dl_go <= 1'h1;
        repeat (40) @(posedge clk);
        dl_go <= 1'h0;
        chk(32'h1, n_reg);
        ts1_go <= 1'h1;
        @(posedge clk);
        ts1_go <= 1'h0;
        wait_seq(1);
        chk(32'h0, n_ee);
        // Load with halt pin, then an error mid-load
        hpin <= 1'h1;
        axi_wr(4'h0, 32'h0, 2'h0);
        dl_go <= 1'h1;
        t = 0;
        while (n_ee == 0 && t < 300) begin
            @(posedge clk); t++;
        end
        chk(32'h1, n_ee);
        axi_wr(4'hc, 32'h1, 2'h0);
        axi_rd(4'hc, 32'h0, 2'h0);
        eee <= 1'h1; ecode <= 4'h5; dl_go <= 1'h0;
        @(posedge clk);
        eee <= 1'h0;
        @(posedge clk);
        axi_rd(4'h0, 32'h8, 2'h0);
        axi_rd(4'h8, 32'h51, 2'h0);
        axi_rd(4'h4, 32'h1, 2'h0);
        chk(32'h0, core_n);
        axi_wr(4'h0, 32'h0, 2'h0);
        wait_seq(2);
        axi_rd(4'hc, 32'h0, 2'h0);
        // Link down again, then a clean load finish
        dl_go <= 1'h1;
        t = 0;
        while (n_ee == 1 && t < 300) begin
            @(posedge clk); t++;
        end
        dl_go <= 1'h0;
        axi_rd(4'h8, 32'h50, 2'h0);
        eed <= 1'h1;
        @(posedge clk);
        eed <= 1'h0;
        wait_seq(3);
        axi_rd(4'h8, 32'h51, 2'h0);
        complete_run();
    end
endmodule : shrs_sequencer_tb
`default_nettype wire
